// ### rurfe_pkg.sv
// Purpose: Shared constants and carriers for the remap unit register front end.
// Assumes: Byte offsets within a two-page (8 KB) window; page 0 holds the fixed map.
// Notes: Page 1 holds the cache flush units and the fault record slots.
package rurfe_pkg;

    // Window geometry
    localparam int ADDR_W = 13;
    localparam int QIDX_W = ADDR_W - 3;

    // Fixed map, page 0 byte offsets
    localparam logic [ADDR_W-1:0] OFF_VERSION = 13'h000;
    localparam logic [ADDR_W-1:0] OFF_FEATURE = 13'h008;
    localparam logic [ADDR_W-1:0] OFF_EXTRA_FEATURE = 13'h010;
    localparam logic [ADDR_W-1:0] OFF_GEN_COMMAND = 13'h018;
    localparam logic [ADDR_W-1:0] OFF_GEN_STATUS = 13'h01c;
    localparam logic [ADDR_W-1:0] OFF_ROOT_PTR = 13'h020;
    localparam logic [ADDR_W-1:0] OFF_CTX_CMD = 13'h028;
    localparam logic [ADDR_W-1:0] OFF_FAULT_STATUS = 13'h034;
    localparam logic [ADDR_W-1:0] OFF_FIRQ_CTRL = 13'h038;
    localparam logic [ADDR_W-1:0] OFF_FIRQ_DATA = 13'h03c;
    localparam logic [ADDR_W-1:0] OFF_FIRQ_ADDR_LO = 13'h040;
    localparam logic [ADDR_W-1:0] OFF_FIRQ_ADDR_HI = 13'h044;
    localparam logic [ADDR_W-1:0] OFF_EXT_FAULT_CFG = 13'h058;
    localparam logic [ADDR_W-1:0] OFF_PROT_ENABLE = 13'h064;
    localparam logic [ADDR_W-1:0] OFF_PROT_LOW_BASE = 13'h068;
    localparam logic [ADDR_W-1:0] OFF_PROT_LOW_LIMIT = 13'h06c;
    localparam logic [ADDR_W-1:0] OFF_PROT_HIGH_BASE = 13'h070;
    localparam logic [ADDR_W-1:0] OFF_PROT_HIGH_LIMIT = 13'h078;
    localparam logic [ADDR_W-1:0] OFF_RESERVED_START = 13'h080;

    // Page 1 arrays: flush unit i at base + 16*i, fault slot j at base + 16*j
    localparam logic [ADDR_W-1:0] OFF_FLUSH_BASE = 13'h1000;
    localparam logic [ADDR_W-1:0] OFF_FAULT_BASE = 13'h1100;
    localparam int SLOT_STRIDE_SHIFT = 4;

    // Version fields
    localparam int VER_MAJOR_LSB = 4;
    localparam int VER_MINOR_LSB = 0;
    localparam logic [3:0] VER_MAJOR = 4'h1;
    localparam logic [3:0] VER_MINOR = 4'h0;

    // Feature report fields filled in by the block
    localparam int FEAT_FIRST_SLOT_LSB = 24;
    localparam int FEAT_FIRST_SLOT_W = 10;
    localparam int FEAT_NUM_SLOT_LSB = 40;
    localparam int FEAT_NUM_SLOT_W = 8;

    // Reserved low bits of the root table pointer (page aligned)
    localparam int ROOT_RSVD_W = 12;

    // Fault status: low sticky write-one-clear event bits
    localparam int FSTS_W = 8;

    // Fault slot: top bit is the sticky write-one-clear "slot holds a fault" flag
    localparam int SLOT_W = 128;
    localparam int SLOT_FLAG_BIT = 127;

    // Register access from the host
    typedef struct packed {
        logic valid;
        logic write;
        logic quad;
        logic [ADDR_W-1:0] addr;
        logic [63:0] wdata;
    } rurfe_req_t;

    typedef struct packed {
        logic valid;
        logic [63:0] rdata;
    } rurfe_rsp_t;

    // Software programmed values steering the rest of the unit
    typedef struct packed {
        logic [63:0] root_ptr;
        logic [63:0] ctx_cmd;
        logic [31:0] firq_ctrl;
        logic [31:0] firq_data;
        logic [31:0] firq_addr_lo;
        logic [31:0] firq_addr_hi;
        logic [63:0] ext_fault_cfg;
        logic [31:0] prot_enable;
        logic [31:0] prot_low_base;
        logic [31:0] prot_low_limit;
        logic [63:0] prot_high_base;
        logic [63:0] prot_high_limit;
    } rurfe_cfg_t;

endpackage : rurfe_pkg

// ### rurfe_regs.sv
// Purpose: Register front end of one address-remapping unit.
// Assumes: One access per request, answered on the next edge; host keeps alignment.
// Notes: Of the two resets, only the power-good reset clears sticky fields.
`timescale 1ns/1ns
`default_nettype none

module rurfe_regs #(
    parameter int NUM_FLUSH = 1,
    parameter int NUM_SLOT = 4,
    parameter logic [63:0] FEATURE_BASE = 64'h0000_0000_0000_0000,
    parameter logic [63:0] EXTRA_FEATURE = 64'h0000_0000_0000_0000
) (
    input wire logic clk_i, // 250 MHz clock
    input wire logic rst_n_i, // Normal reset, async, active low
    input wire logic pwrgood_rst_n_i, // Power-good reset, async, active low
    input wire rurfe_pkg::rurfe_req_t req_i, // Host register access
    output rurfe_pkg::rurfe_rsp_t rsp_o, // Registered answer
    output logic [31:0] gen_cmd_o, // Command word, held one cycle
    output logic gen_cmd_wr_o, // Pulse on command write
    input wire logic [31:0] gen_status_i, // Status from unit logic
    input wire logic [rurfe_pkg::FSTS_W-1:0] fault_event_i, // Sets fault status bits
    input wire logic rec_valid_i, // Record a fault into a slot
    input wire logic [7:0] rec_index_i, // Slot to record into
    input wire logic [rurfe_pkg::SLOT_W-2:0] rec_data_i, // Record contents
    output rurfe_pkg::rurfe_cfg_t cfg_o, // Programmed values
    output logic [NUM_FLUSH-1:0][63:0] flush_addr_o, // Flush unit address words
    output logic [NUM_FLUSH-1:0][63:0] flush_cmd_o // Flush unit command words
);

    localparam int AW = rurfe_pkg::ADDR_W;
    localparam int QW = rurfe_pkg::QIDX_W;
    localparam logic [AW-1:0] FIRST_SLOT_UNITS = rurfe_pkg::OFF_FAULT_BASE >> 4;

    rurfe_pkg::rurfe_cfg_t cfg;
    logic [rurfe_pkg::FSTS_W-1:0] fault_status;
    logic [NUM_SLOT-1:0][rurfe_pkg::SLOT_W-1:0] slot;
    logic [NUM_FLUSH-1:0][63:0] flush_addr;
    logic [NUM_FLUSH-1:0][63:0] flush_cmd;
    logic [31:0] gen_cmd;
    logic gen_cmd_wr;
    rurfe_pkg::rurfe_rsp_t rsp;

    // Access decode: split a quad into lower and upper dword lanes
    wire logic aligned = (req_i.addr[1:0] == 2'b00) && !(req_i.quad && req_i.addr[2]);
    wire logic wr = req_i.valid && req_i.write && aligned;
    wire logic lo_we = wr && (req_i.quad || !req_i.addr[2]);
    wire logic hi_we = wr && (req_i.quad || req_i.addr[2]);
    wire logic [31:0] lo_wd = req_i.wdata[31:0];
    wire logic [31:0] hi_wd = req_i.quad ? req_i.wdata[63:32] : req_i.wdata[31:0];
    wire logic [QW-1:0] qidx = req_i.addr[AW-1:3];
    wire logic page1 = req_i.addr[AW-1];
    wire logic [7:0] unit_idx = req_i.addr[11:4];
    wire logic unit_hi_q = req_i.addr[3];
    wire logic flush_hit = page1 && (req_i.addr < rurfe_pkg::OFF_FAULT_BASE)
        && (32'(unit_idx) < NUM_FLUSH);
    wire logic slot_hit = page1 && (req_i.addr >= rurfe_pkg::OFF_FAULT_BASE)
        && (32'(unit_idx) - 32'h10 < NUM_SLOT);
    wire logic [7:0] slot_idx = unit_idx - 8'h10;

    // Qword hit wires for the fixed map
    function automatic logic hitq(input logic [QW-1:0] q, input logic [AW-1:0] off);
        hitq = (q == off[AW-1:3]);
    endfunction : hitq

    wire logic h_gen = hitq(qidx, rurfe_pkg::OFF_GEN_COMMAND);
    wire logic h_root = hitq(qidx, rurfe_pkg::OFF_ROOT_PTR);
    wire logic h_ctx = hitq(qidx, rurfe_pkg::OFF_CTX_CMD);
    wire logic h_fsts = hitq(qidx, rurfe_pkg::OFF_FAULT_STATUS);
    wire logic h_firq = hitq(qidx, rurfe_pkg::OFF_FIRQ_CTRL);
    wire logic h_fadr = hitq(qidx, rurfe_pkg::OFF_FIRQ_ADDR_LO);
    wire logic h_efl = hitq(qidx, rurfe_pkg::OFF_EXT_FAULT_CFG);
    wire logic h_pen = hitq(qidx, rurfe_pkg::OFF_PROT_ENABLE);
    wire logic h_plo = hitq(qidx, rurfe_pkg::OFF_PROT_LOW_LIMIT);
    wire logic h_phb = hitq(qidx, rurfe_pkg::OFF_PROT_HIGH_BASE);
    wire logic h_phl = hitq(qidx, rurfe_pkg::OFF_PROT_HIGH_LIMIT);

    // Feature report with slot count minus one and first slot location inserted
    wire logic [63:0] feature = {FEATURE_BASE[63:48],
        8'(NUM_SLOT - 1),
        FEATURE_BASE[39:34],
        FIRST_SLOT_UNITS[rurfe_pkg::FEAT_FIRST_SLOT_W-1:0],
        FEATURE_BASE[23:0]};

    // Merge lanes into a 64-bit read-write value
    function automatic logic [63:0] upd64(input logic [63:0] old, input logic lw,
        input logic hw, input logic [31:0] ld, input logic [31:0] hd);
        upd64 = {hw ? hd : old[63:32], lw ? ld : old[31:0]};
    endfunction : upd64

    // Version word: major and minor fields, upper bits zero
    wire logic [31:0] version = {24'h00_0000, rurfe_pkg::VER_MAJOR,
        rurfe_pkg::VER_MINOR};

    // Read data of the addressed qword, lower and upper dwords
    logic [31:0] rd_lo;
    logic [31:0] rd_hi;
    always_comb
    begin
        rd_lo = 32'h0000_0000;
        rd_hi = 32'h0000_0000;
        if (page1)
        begin
            if (flush_hit)
            begin
                {rd_hi, rd_lo} = unit_hi_q ? flush_cmd[unit_idx] : flush_addr[unit_idx];
            end
            else if (slot_hit)
            begin
                {rd_hi, rd_lo} = unit_hi_q ? slot[slot_idx][127:64] : slot[slot_idx][63:0];
            end
        end
        else if (req_i.addr < rurfe_pkg::OFF_RESERVED_START)
        begin
            case (qidx)
                rurfe_pkg::OFF_VERSION[AW-1:3]: rd_lo = version;
                rurfe_pkg::OFF_FEATURE[AW-1:3]: {rd_hi, rd_lo} = feature;
                rurfe_pkg::OFF_EXTRA_FEATURE[AW-1:3]: {rd_hi, rd_lo} = EXTRA_FEATURE;
                rurfe_pkg::OFF_GEN_COMMAND[AW-1:3]: rd_hi = gen_status_i;
                rurfe_pkg::OFF_ROOT_PTR[AW-1:3]: {rd_hi, rd_lo} = cfg.root_ptr;
                rurfe_pkg::OFF_CTX_CMD[AW-1:3]: {rd_hi, rd_lo} = cfg.ctx_cmd;
                rurfe_pkg::OFF_FAULT_STATUS[AW-1:3]: rd_hi = 32'(fault_status);
                rurfe_pkg::OFF_FIRQ_CTRL[AW-1:3]: {rd_hi, rd_lo} = {cfg.firq_data,
                    cfg.firq_ctrl};
                rurfe_pkg::OFF_FIRQ_ADDR_LO[AW-1:3]: {rd_hi, rd_lo} = {cfg.firq_addr_hi,
                    cfg.firq_addr_lo};
                rurfe_pkg::OFF_EXT_FAULT_CFG[AW-1:3]: {rd_hi, rd_lo} = cfg.ext_fault_cfg;
                rurfe_pkg::OFF_PROT_ENABLE[AW-1:3]: rd_hi = cfg.prot_enable;
                rurfe_pkg::OFF_PROT_LOW_BASE[AW-1:3]: {rd_hi, rd_lo} = {cfg.prot_low_limit,
                    cfg.prot_low_base};
                rurfe_pkg::OFF_PROT_HIGH_BASE[AW-1:3]: {rd_hi, rd_lo} = cfg.prot_high_base;
                rurfe_pkg::OFF_PROT_HIGH_LIMIT[AW-1:3]: {rd_hi, rd_lo} = cfg.prot_high_limit;
                default:
                begin
                    rd_lo = 32'h0000_0000;
                    rd_hi = 32'h0000_0000;
                end
            endcase
        end
    end

    // Answer selects the lane for dword reads
    wire logic [63:0] rd_word = req_i.quad ? {rd_hi, rd_lo}
        : {32'h0000_0000, req_i.addr[2] ? rd_hi : rd_lo};

    // Answer register, one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.valid <= req_i.valid;
            rsp.rdata <= (req_i.valid && !req_i.write && aligned) ? rd_word : 64'h0;
        end
    end

    // Read-write configuration, normal reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg <= '0;
        end
        else if (!page1)
        begin
            if (h_root)
            begin
                cfg.root_ptr <= upd64(cfg.root_ptr, lo_we, hi_we,
                    {lo_wd[31:12], 12'h000}, hi_wd);
            end
            if (h_ctx) cfg.ctx_cmd <= upd64(cfg.ctx_cmd, lo_we, hi_we, lo_wd, hi_wd);
            if (h_firq)
                {cfg.firq_data, cfg.firq_ctrl} <= upd64({cfg.firq_data, cfg.firq_ctrl},
                    lo_we, hi_we, lo_wd, hi_wd);
            if (h_fadr)
                {cfg.firq_addr_hi, cfg.firq_addr_lo} <= upd64({cfg.firq_addr_hi,
                    cfg.firq_addr_lo}, lo_we, hi_we, lo_wd, hi_wd);
            if (h_efl)
                cfg.ext_fault_cfg <= upd64(cfg.ext_fault_cfg, lo_we, hi_we, lo_wd, hi_wd);
            if (h_pen && hi_we) cfg.prot_enable <= hi_wd;
            if (h_plo)
                {cfg.prot_low_limit, cfg.prot_low_base} <= upd64({cfg.prot_low_limit,
                    cfg.prot_low_base}, lo_we, hi_we, lo_wd, hi_wd);
            if (h_phb)
                cfg.prot_high_base <= upd64(cfg.prot_high_base, lo_we, hi_we, lo_wd, hi_wd);
            if (h_phl)
                cfg.prot_high_limit <= upd64(cfg.prot_high_limit, lo_we, hi_we, lo_wd, hi_wd);
        end
    end

    // Write-only command word, forwarded as a one-cycle pulse
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gen_cmd <= 32'h0000_0000;
            gen_cmd_wr <= 1'b0;
        end
        else
        begin
            gen_cmd_wr <= !page1 && h_gen && lo_we;
            gen_cmd <= (!page1 && h_gen && lo_we) ? lo_wd : 32'h0000_0000;
        end
    end

    // Flush units: pairs of 64-bit read-write words
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flush_addr <= '0;
            flush_cmd <= '0;
        end
        else if (flush_hit)
        begin
            if (unit_hi_q)
                flush_cmd[unit_idx] <= upd64(flush_cmd[unit_idx], lo_we, hi_we,
                    lo_wd, hi_wd);
            else
                flush_addr[unit_idx] <= upd64(flush_addr[unit_idx], lo_we, hi_we,
                    lo_wd, hi_wd);
        end
    end

    // Fault status, sticky; a new event wins over a same-cycle clear
    wire logic [rurfe_pkg::FSTS_W-1:0] fsts_clr = (!page1 && h_fsts && hi_we)
        ? hi_wd[rurfe_pkg::FSTS_W-1:0] : '0;
    always_ff @(posedge clk_i or negedge pwrgood_rst_n_i)
    begin
        if (!pwrgood_rst_n_i)
            fault_status <= '0;
        else
            fault_status <= (fault_status & ~fsts_clr) | fault_event_i;
    end

    // Fault slots: sticky record fields, flag bit cleared by writing one
    always_ff @(posedge clk_i or negedge pwrgood_rst_n_i)
    begin
        if (!pwrgood_rst_n_i)
        begin
            slot <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_SLOT; i++)
            begin
                if (slot_hit && unit_hi_q && hi_we && (32'(slot_idx) == i)
                    && hi_wd[31])
                    slot[i][rurfe_pkg::SLOT_FLAG_BIT] <= 1'b0;
                if (rec_valid_i && (32'(rec_index_i) == i))
                    slot[i] <= {1'b1, rec_data_i};
            end
        end
    end

    assign rsp_o = rsp;
    assign gen_cmd_o = gen_cmd;
    assign gen_cmd_wr_o = gen_cmd_wr;
    assign cfg_o = cfg;
    assign flush_addr_o = flush_addr;
    assign flush_cmd_o = flush_cmd;

endmodule : rurfe_regs
`default_nettype wire

// ### rurfe_regs_checker.sv
// Purpose: Port assertions for the remap unit register front end.
// Assumes: Every request is answered exactly one cycle later.
// Notes: Bound to every rurfe_regs instance.
`timescale 1ns/1ns
`default_nettype none
module rurfe_regs_checker #(
    parameter int NUM_FLUSH = 1
) (
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Normal reset
    input wire rurfe_pkg::rurfe_req_t req_i, // Host access
    input wire rurfe_pkg::rurfe_rsp_t rsp_o, // Answer
    input wire logic [31:0] gen_cmd_o, // Command word
    input wire logic gen_cmd_wr_o, // Command pulse
    input wire rurfe_pkg::rurfe_cfg_t cfg_o, // Programmed values
    input wire logic [NUM_FLUSH-1:0][63:0] flush_addr_o // Flush address words
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Request decode
    wire [12:0] a = req_i.addr;
    wire [63:0] wd = req_i.wdata;
    wire [31:0] wd32 = req_i.wdata[31:0];
    wire rd = req_i.valid && !req_i.write;
    wire wr = req_i.valid && req_i.write;
    wire wq = wr && req_i.quad;
    wire cmd_wr = wr && a == rurfe_pkg::OFF_GEN_COMMAND;
    wire rsvd_dw = a inside {13'h004, 13'h030, 13'h048, 13'h050, 13'h060};
    wire rsvd = rsvd_dw || (a >= 13'h080 && a <= 13'hfff);
    // A quad read at 030h or 060h carries a live register in its upper half
    wire upper_live = req_i.quad && (a == 13'h030 || a == 13'h060);
    property p_answer; 1'b1 |=> rsp_o.valid == $past(req_i.valid); endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle after request");
    property p_version; rd && a == 13'h000 |=> rsp_o.rdata == 64'h10; endproperty
    a_version: assert property (p_version) else $error("version word wrong");
    property p_reserved;
        rd && rsvd |=> rsp_o.rdata[31:0] == 32'h0
            && ($past(upper_live) || rsp_o.rdata[63:32] == 32'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read not zero");
    property p_cmd; cmd_wr |=> gen_cmd_wr_o && gen_cmd_o == $past(wd32); endproperty
    a_cmd: assert property (p_cmd) else $error("command write not passed on");
    property p_cmd_src; gen_cmd_wr_o |-> $past(cmd_wr); endproperty
    a_cmd_src: assert property (p_cmd_src) else $error("command pulse without write");
    property p_root; wq && a == 13'h020 |=> cfg_o.root_ptr == ($past(wd) & ~64'hfff); endproperty
    a_root: assert property (p_root) else $error("root pointer quad write wrong");
    property p_hold; !wr |=> $stable(cfg_o); endproperty
    a_hold: assert property (p_hold) else $error("config changed without write");
    property p_flush; wq && a == 13'h1000 |=> flush_addr_o[0] == $past(wd); endproperty
    a_flush: assert property (p_flush) else $error("flush word not stored");
    // Main scenarios
    c_split: cover property (wq && a == 13'h070);
    c_back: cover property (rsp_o.valid ##1 rsp_o.valid);
    c_cmd: cover property (gen_cmd_wr_o);
endmodule : rurfe_regs_checker
bind rurfe_regs rurfe_regs_checker #(.NUM_FLUSH(NUM_FLUSH)) i_chk (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .rsp_o(rsp_o), .gen_cmd_o(gen_cmd_o),
    .gen_cmd_wr_o(gen_cmd_wr_o), .cfg_o(cfg_o), .flush_addr_o(flush_addr_o));
`default_nettype wire

// ### tb_rurfe_regs.sv
// Purpose: Self-checking bench for the remap unit register front end.
// Assumes: Answers come in request order, one cycle after each request.
// Notes: The driver queues expected read data; a monitor checks it.
`timescale 1ns/1ns
`default_nettype none
module tb_rurfe_regs;
    localparam int NSLOT = 4;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pwrgood_rst_n = 1'b0;
    rurfe_pkg::rurfe_req_t req = '0;
    rurfe_pkg::rurfe_rsp_t rsp;
    rurfe_pkg::rurfe_cfg_t cfg;
    logic [31:0] gen_cmd;
    logic gen_cmd_wr;
    logic [31:0] status = 32'h0;
    logic [7:0] fev = 8'h0;
    logic rec_v = 1'b0;
    logic [7:0] rec_idx = 8'h1;
    logic [126:0] rec_d = '0;
    logic [0:0][63:0] fl_a;
    logic [0:0][63:0] fl_c;
    logic [63:0] exp_q[$];
    logic [63:0] r;
    logic [12:0] dw_offs[7] = '{13'h038, 13'h03c, 13'h040, 13'h044, 13'h064, 13'h068, 13'h06c};
    logic [12:0] qw_offs[6] = '{13'h028, 13'h058, 13'h070, 13'h1000, 13'h1008, 13'h078};
    logic [12:0] rs_offs[8] = '{13'h004, 13'h030, 13'h048, 13'h050, 13'h060, 13'h080,
        13'hffc, 13'h1800};
    int fails = 0;
    int checked = 0;
    always #2 clk_i = ~clk_i;
    rurfe_regs #(.NUM_FLUSH(1), .NUM_SLOT(NSLOT)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .pwrgood_rst_n_i(pwrgood_rst_n), .req_i(req), .rsp_o(rsp), .gen_cmd_o(gen_cmd),
        .gen_cmd_wr_o(gen_cmd_wr), .gen_status_i(status), .fault_event_i(fev),
        .rec_valid_i(rec_v), .rec_index_i(rec_idx), .rec_data_i(rec_d), .cfg_o(cfg),
        .flush_addr_o(fl_a), .flush_cmd_o(fl_c));
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One access; k is {write, quad}
    task acc(input logic [1:0] k, input logic [12:0] a, input logic [63:0] d,
        input logic [63:0] e);
        @(posedge clk_i);
        req <= '{1'b1, k[1], k[0], a, d};
        exp_q.push_back(e);
    endtask : acc
    task idle(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            req <= '0;
        end
    endtask : idle
    task print_verdict();
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // Answer monitor, sampled mid-cycle
    always @(negedge clk_i)
    begin
        if (rsp.valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("extra answer", 64'h1, 64'h0);
            else
                chk("rdata", rsp.rdata, exp_q.pop_front());
        end
        // The only command write carries all ones
        if (gen_cmd_wr === 1'b1)
            chk("gen_cmd", {32'h0, gen_cmd}, 64'hffff_ffff);
    end
    initial
    begin
        r = {32'h0, $urandom(32'h9eef)};
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        pwrgood_rst_n <= 1'b1;
        status <= $urandom();
        // Version, feature and status words ignore writes
        acc(2'b10, 13'h000, ~64'h0, 64'h0);
        acc(2'b00, 13'h000, 64'h0, 64'h10);
        acc(2'b11, 13'h008, ~64'h0, 64'h0);
        acc(2'b01, 13'h008, 64'h0, (64'(NSLOT - 1) << 40) | (64'h110 << 24));
        acc(2'b01, 13'h010, 64'h0, 64'h0);
        acc(2'b10, 13'h01c, ~64'h0, 64'h0);
        acc(2'b00, 13'h01c, 64'h0, {32'h0, status});
        acc(2'b10, 13'h018, ~64'h0, 64'h0);
        acc(2'b00, 13'h018, 64'h0, 64'h0);
        // Read-write words, back to back
        foreach (dw_offs[i])
        begin
            r = {$urandom(), $urandom()};
            acc(2'b10, dw_offs[i], r, 64'h0);
            acc(2'b00, dw_offs[i], 64'h0, {32'h0, r[31:0]});
        end
        foreach (qw_offs[i])
        begin
            r = {$urandom(), $urandom()};
            acc(2'b11, qw_offs[i], r, 64'h0);
            acc(2'b01, qw_offs[i], 64'h0, r);
        end
        // Quad split into lower then upper dword
        acc(2'b00, 13'h078, 64'h0, {32'h0, r[31:0]});
        acc(2'b00, 13'h07c, 64'h0, {32'h0, r[63:32]});
        acc(2'b10, 13'h07c, 64'h5a5a_5a5a, 64'h0);
        acc(2'b01, 13'h078, 64'h0, {32'h5a5a_5a5a, r[31:0]});
        acc(2'b11, 13'h020, r, 64'h0);
        acc(2'b01, 13'h020, 64'h0, r & ~64'hfff);
        // Reserved space reads zero and keeps nothing
        foreach (rs_offs[i])
        begin
            acc(2'b10, rs_offs[i], ~64'h0, 64'h0);
            acc(2'b00, rs_offs[i], 64'h0, 64'h0);
        end
        // Aligned writes at 038h and 040h are kept; misaligned accesses are answered but ignored
        acc(2'b11, 13'h038, r, 64'h0);
        acc(2'b10, 13'h040, r, 64'h0);
        acc(2'b11, 13'h03c, ~64'h0, 64'h0);
        acc(2'b10, 13'h03e, ~64'h0, 64'h0);
        acc(2'b00, 13'h03e, 64'h0, 64'h0);
        acc(2'b01, 13'h038, 64'h0, r);
        idle(2);
        chk("firq_data", {32'h0, cfg.firq_data}, {32'h0, r[63:32]});
        chk("firq_addr_lo", {32'h0, cfg.firq_addr_lo}, {32'h0, r[31:0]});
        // Fault events and a record, then write-one-clear
        fev <= 8'h5a;
        rec_v <= 1'b1;
        rec_d <= 127'({$urandom(), $urandom(), $urandom(), $urandom()});
        @(posedge clk_i);
        fev <= 8'h00;
        rec_v <= 1'b0;
        acc(2'b00, 13'h034, 64'h0, 64'h5a);
        acc(2'b10, 13'h034, 64'h0f, 64'h0);
        acc(2'b00, 13'h034, 64'h0, 64'h50);
        acc(2'b10, 13'h034, 64'h0, 64'h0);
        acc(2'b00, 13'h034, 64'h0, 64'h50);
        acc(2'b01, 13'h1110, 64'h0, rec_d[63:0]);
        acc(2'b01, 13'h1118, 64'h0, {1'b1, rec_d[126:64]});
        idle(3);
        // Normal reset keeps sticky state only
        rst_n_i <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        acc(2'b00, 13'h034, 64'h0, 64'h50);
        acc(2'b01, 13'h1118, 64'h0, {1'b1, rec_d[126:64]});
        acc(2'b00, 13'h038, 64'h0, 64'h0);
        acc(2'b11, 13'h1118, 64'h8000_0000_0000_0000, 64'h0);
        acc(2'b01, 13'h1118, 64'h0, {1'b0, rec_d[126:64]});
        idle(3);
        // Power-good reset clears sticky state
        rst_n_i <= 1'b0;
        pwrgood_rst_n <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        pwrgood_rst_n <= 1'b1;
        acc(2'b00, 13'h034, 64'h0, 64'h0);
        acc(2'b01, 13'h1110, 64'h0, 64'h0);
        idle(1);
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk_i);
        chk("pending answers", 64'(exp_q.size()), 64'h0);
        print_verdict();
    end
endmodule : tb_rurfe_regs
`default_nettype wire
